// ==== adcpf_pkg.sv ====
// Package for the scan and power-fail compare sequencer.
// Assumes a 32-bit classic Wishbone register bus and a 10-bit SAR core.
package adcpf_pkg;
	localparam int ADCPF_NCH    = 8;
	localparam int ADCPF_CHW    = 3;
	localparam int ADCPF_RESW   = 10;
	localparam int ADCPF_THRW   = 8;
	// Byte addresses of registers
	localparam logic [7:0] ADCPF_OFF_MODE   = 8'h00;
	localparam logic [7:0] ADCPF_OFF_CHSEL  = 8'h04;
	localparam logic [7:0] ADCPF_OFF_CMPM   = 8'h08;
	localparam logic [7:0] ADCPF_OFF_THR    = 8'h0C;
	localparam logic [7:0] ADCPF_OFF_IRQST  = 8'h10;
	localparam logic [7:0] ADCPF_OFF_IRQMSK = 8'h14;
	localparam logic [7:0] ADCPF_OFF_RES0   = 8'h20;
	// Mode register fields
	localparam int ADCPF_BIT_CE   = 0;
	localparam int ADCPF_BIT_MD0  = 1;
	localparam int ADCPF_BIT_EF   = 3;
	// Compare mode fields
	localparam int ADCPF_BIT_PFE  = 0;
	localparam int ADCPF_BIT_PFC  = 1;
	// Status and mask fields
	localparam int ADCPF_BIT_END  = 0;
	// Reset values
	localparam logic [2:0] ADCPF_RST_MODE  = 3'h0;
	localparam logic [7:0] ADCPF_RST_THR   = 8'h00;
	localparam logic [1:0] ADCPF_RST_CMPM  = 2'h0;
	// Operation modes
	typedef enum logic [1:0]
	{
		ADCPF_CONT_SEL  = 2'b00,
		ADCPF_CONT_SCAN = 2'b01,
		ADCPF_ONE_SEL   = 2'b10,
		ADCPF_ONE_SCAN  = 2'b11
	} adcpf_mode_t;
	typedef enum logic [1:0]
	{
		ADCPF_IDLE = 2'b00,
		ADCPF_REQ  = 2'b01,
		ADCPF_WAIT = 2'b10
	} adcpf_state_t;
endpackage

// ==== adcpf_result_mem.sv ====
// Result store, one word per analog channel.
// Assumes a single writer and a registered read port.
`timescale 1ns/100ps
module adcpf_result_mem
#(
	parameter int DEPTH = 8,
	parameter int AW    = 3,
	parameter int DW    = 10
)
(
	// Clock
	input  wire logic          sys_clk,
	// Write port
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [DW-1:0] wrData,
	// Read port
	input  wire logic [AW-1:0] rdAddr,
	output logic      [DW-1:0] rdData
);
	logic [DW-1:0] mem [DEPTH];

	always_ff @(posedge sys_clk)
	begin
		if (wrEn)
			mem[wrAddr] <= wrData;
		rdData <= mem[rdAddr];
	end
endmodule

// ==== adcpf_ctrl.sv ====
// Sequencer, power-fail compare and Wishbone slave of the converter.
// Assumes a SAR core with start/done handshake and a channel select input.
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/100ps
module adcpf_ctrl
	import adcpf_pkg::*;
#(
	parameter int NCH = adcpf_pkg::ADCPF_NCH
)
(
	// Clock and reset
	input  wire logic                              sys_clk,
	input  wire logic                              rst,
	// Wishbone slave
	input  wire logic                              wb_cyc_i,
	input  wire logic                              wb_stb_i,
	input  wire logic                              wb_we_i,
	input  wire logic [7:0]                        wb_adr_i,
	input  wire logic [3:0]                        wb_sel_i,
	input  wire logic [31:0]                       wb_dat_i,
	output logic      [31:0]                       wb_dat_o,
	output logic                                   wb_ack_o,
	// SAR core
	output logic                                   convStart,
	output logic      [adcpf_pkg::ADCPF_CHW-1:0]   analogInputChannel,
	input  wire logic                              convDone,
	input  wire logic [adcpf_pkg::ADCPF_RESW-1:0]  convData,
	// Interrupt
	output logic                                   conversionEndIrq
);
	import adcpf_pkg::*;

	typedef struct packed
	{
		logic                  ce;
		adcpf_mode_t           mode;
		logic                  ef;
		logic [ADCPF_CHW-1:0]  chSel;
		logic                  pfe;
		logic                  pfc;
		logic [ADCPF_THRW-1:0] thr;
		logic                  st;
		logic                  msk;
		adcpf_state_t          fsm;
		logic [ADCPF_CHW-1:0]  ch;
		logic                  gate;
		logic                  ack;
		logic                  rdMem;
		logic [31:0]           dat;
		logic                  start;
		logic                  irq;
	} adcpf_state_s_t;

	adcpf_state_s_t cur_r, cur_nxt;

	logic                 memWr;
	logic [ADCPF_RESW-1:0] memRd;

	// Unsigned compare of upper result bits
	function automatic logic cmpHit(input logic [ADCPF_RESW-1:0] d, input logic [ADCPF_THRW-1:0] t,
		input logic c);
		logic [ADCPF_THRW-1:0] hi;
		hi = d[ADCPF_RESW-1 -: ADCPF_THRW];
		cmpHit = c ? (hi < t) : (hi >= t);
	endfunction

	function automatic logic isScan(input adcpf_mode_t m);
		isScan = (m == ADCPF_CONT_SCAN) || (m == ADCPF_ONE_SCAN);
	endfunction

	adcpf_result_mem
	#(
		.DEPTH (NCH),
		.AW    (ADCPF_CHW),
		.DW    (ADCPF_RESW)
	)
	u_mem
	(
		.sys_clk (sys_clk),
		.wrEn    (memWr),
		.wrAddr  (cur_r.ch),
		.wrData  (convData),
		.rdAddr  (wb_adr_i[ADCPF_CHW+1:2]),
		.rdData  (memRd)
	);

	// Every completion in WAIT is stored regardless of compare outcome
	assign memWr = (cur_r.fsm == ADCPF_WAIT) && convDone && cur_r.ce;

	always_comb
	begin
		logic req;
		logic wr;
		logic done;
		logic last;
		logic hit;
		logic evt;
		logic abort;
		req  = 1'b0;
		wr   = 1'b0;
		done = 1'b0;
		last = 1'b0;
		hit  = 1'b0;
		evt  = 1'b0;
		abort = 1'b0;
		cur_nxt = cur_r;
		cur_nxt.start = 1'b0;

		// Bus slave: one wait state, ack dropped after one cycle
		req = wb_cyc_i && wb_stb_i && !cur_r.ack;
		wr  = req && wb_we_i && wb_sel_i[0];
		// Only config writes abort; status and mask writes must not lose a completion
		abort = wr && (wb_adr_i <= ADCPF_OFF_THR);
		cur_nxt.ack   = req;
		cur_nxt.rdMem = 1'b0;
		if (req && !wb_we_i)
		begin
			cur_nxt.dat = 32'h0000_0000;
			// Result window is eight words; anything above it reads as zero
			if (wb_adr_i[7:5] == ADCPF_OFF_RES0[7:5])
				cur_nxt.rdMem = 1'b1;
			else
				unique case (wb_adr_i)
					ADCPF_OFF_MODE:   cur_nxt.dat[3:0] = {cur_r.ef, cur_r.mode, cur_r.ce};
					ADCPF_OFF_CHSEL:  cur_nxt.dat[ADCPF_CHW-1:0] = cur_r.chSel;
					ADCPF_OFF_CMPM:   cur_nxt.dat[1:0] = {cur_r.pfc, cur_r.pfe};
					ADCPF_OFF_THR:    cur_nxt.dat[ADCPF_THRW-1:0] = cur_r.thr;
					ADCPF_OFF_IRQST:  cur_nxt.dat[ADCPF_BIT_END] = cur_r.st;
					ADCPF_OFF_IRQMSK: cur_nxt.dat[ADCPF_BIT_END] = cur_r.msk;
					default:          cur_nxt.dat = 32'h0000_0000;
				endcase
		end

		// Config writes restart the sequence from the beginning
		if (wr)
		begin
			unique case (wb_adr_i)
				ADCPF_OFF_MODE:
				begin
					cur_nxt.ce   = wb_dat_i[ADCPF_BIT_CE];
					cur_nxt.mode = adcpf_mode_t'(wb_dat_i[ADCPF_BIT_MD0 +: 2]);
					cur_nxt.fsm  = ADCPF_IDLE;
				end
				ADCPF_OFF_CHSEL:
				begin
					cur_nxt.chSel = wb_dat_i[ADCPF_CHW-1:0];
					cur_nxt.fsm   = ADCPF_IDLE;
				end
				ADCPF_OFF_CMPM:
				begin
					cur_nxt.pfe = wb_dat_i[ADCPF_BIT_PFE];
					cur_nxt.pfc = wb_dat_i[ADCPF_BIT_PFC];
					cur_nxt.fsm = ADCPF_IDLE;
				end
				ADCPF_OFF_THR:
				begin
					cur_nxt.thr = wb_dat_i[ADCPF_THRW-1:0];
					cur_nxt.fsm = ADCPF_IDLE;
				end
				ADCPF_OFF_IRQMSK: cur_nxt.msk = wb_dat_i[ADCPF_BIT_END];
				default:          cur_nxt.msk = cur_r.msk;
			endcase
		end

		// Sequencer
		unique case (cur_r.fsm)
			ADCPF_IDLE:
			begin
				if (cur_r.ce && !abort)
				begin
					cur_nxt.ch    = isScan(cur_r.mode) ? '0 : cur_r.chSel;
					cur_nxt.gate  = 1'b1;
					cur_nxt.start = 1'b1;
					cur_nxt.ef    = 1'b1;
					cur_nxt.fsm   = ADCPF_WAIT;
				end
			end
			ADCPF_REQ:
			begin
				if (!abort)
				begin
					cur_nxt.start = 1'b1;
					cur_nxt.fsm   = ADCPF_WAIT;
				end
			end
			ADCPF_WAIT:
			begin
				if (convDone && !abort)
				begin
					done = 1'b1;
					last = !isScan(cur_r.mode) || (cur_r.ch == cur_r.chSel);
					hit  = cmpHit(convData, cur_r.thr, cur_r.pfc);
					// Scan modes judge channel 0 only
					if (cur_r.pfe && (cur_r.ch == '0 || !isScan(cur_r.mode)))
						cur_nxt.gate = hit;
					if (last)
					begin
						// Compare off always passes; on, gate holds outcome
						evt = cur_r.pfe ? (isScan(cur_r.mode) ? (cur_r.ch == '0 ? hit : cur_r.gate) : hit)
							: 1'b1;
						if (cur_r.mode == ADCPF_ONE_SEL || cur_r.mode == ADCPF_ONE_SCAN)
						begin
							cur_nxt.ce  = 1'b0;
							cur_nxt.ef  = 1'b0;
							cur_nxt.fsm = ADCPF_IDLE;
						end
						else
						begin
							cur_nxt.ch   = isScan(cur_r.mode) ? '0 : cur_r.chSel;
							cur_nxt.gate = 1'b1;
							cur_nxt.fsm  = ADCPF_REQ;
						end
					end
					else
					begin
						cur_nxt.ch  = cur_r.ch + 1'b1;
						cur_nxt.fsm = ADCPF_REQ;
					end
				end
			end
			default: cur_nxt.fsm = ADCPF_IDLE;
		endcase

		// Enable cleared: back to idle, ef and start cleared
		if (!cur_nxt.ce)
		begin
			cur_nxt.fsm   = ADCPF_IDLE;
			cur_nxt.ef    = 1'b0;
			cur_nxt.start = 1'b0;
		end

		// Sticky status: set beats write-one clear
		if (wr && wb_adr_i == ADCPF_OFF_IRQST && wb_dat_i[ADCPF_BIT_END])
			cur_nxt.st = 1'b0;
		if (done && evt)
			cur_nxt.st = 1'b1;
		cur_nxt.irq = cur_nxt.st && cur_nxt.msk;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			cur_r       <= '0;
			cur_r.mode  <= ADCPF_CONT_SEL;
			cur_r.fsm   <= ADCPF_IDLE;
			cur_r.thr   <= ADCPF_RST_THR;
			cur_r.gate  <= 1'b1;
		end
		else
			cur_r <= cur_nxt;
	end

	assign wb_ack_o           = cur_r.ack;
	assign wb_dat_o           = cur_r.rdMem ? {22'h00_0000, memRd} : cur_r.dat;
	assign convStart          = cur_r.start;
	assign analogInputChannel = cur_r.ch;
	assign conversionEndIrq   = cur_r.irq;
endmodule

// ==== adcpf_ctrl_chk.sv ====
// Checker of bus, start and interrupt timing at the sequencer ports.
// Assumes binding onto adcpf_ctrl, one clock domain.
`timescale 1ns/100ps
module adcpf_ctrl_chk
	import adcpf_pkg::*;
(
	// Clock, reset and bus
	input wire logic				sys_clk,
	input wire logic				rst,
	input wire logic				wb_cyc_i,
	input wire logic				wb_stb_i,
	input wire logic				wb_ack_o,
	// Core and interrupt
	input wire logic				convStart,
	input wire logic [adcpf_pkg::ADCPF_CHW-1:0]	analogInputChannel,
	input wire logic				convDone,
	input wire logic				conversionEndIrq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence taken; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence quiet; !convDone && !$past(convDone) && !wb_cyc_i && !$past(wb_cyc_i); endsequence
	a_ack_follow: assert property (taken |=> wb_ack_o) else $error("no ack");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
	a_start_single: assert property (convStart |=> !convStart) else $error("start too long");
	a_chan_hold: assert property (quiet |=> $stable(analogInputChannel) || convStart)
		else $error("channel moved");
	a_irq_hold: assert property (conversionEndIrq && !wb_cyc_i |=> conversionEndIrq)
		else $error("irq dropped");
	a_irq_cause: assert property ($rose(conversionEndIrq) |-> $past(convDone) || $past(convDone, 2) || $past(wb_cyc_i))
		else $error("irq uncaused");
	a_reset_quiet: assert property ($fell(rst) |-> !wb_ack_o && !convStart && !conversionEndIrq)
		else $error("busy after reset");
endmodule

// ==== adcpf_sar_model.sv ====
// SAR core model: answers each start pulse after DLY cycles.
// Assumes one clock; channel levels come from the bench.
`timescale 1ns/100ps
module adcpf_sar_model
#(parameter int DLY = 4)
(
	// Clock, handshake and levels
	input wire logic	sys_clk,
	input wire logic	convStart,
	input wire logic [2:0]	analogInputChannel,
	output logic		convDone = 1'b0,
	output logic [9:0]	convData = 10'h000,
	input wire logic [79:0]	levels
);
	int		cnt = 0;
	logic [2:0]	ch = 3'h0;
	always @(posedge sys_clk)
	begin
		convDone <= 1'b0;
		convData <= ~convData; // Data not held between answers
		cnt <= (cnt > 0) ? cnt - 1 : 0;
		if (convStart)
		begin
			cnt <= DLY;
			ch <= analogInputChannel;
		end
		else if (cnt == 1)
		begin
			convDone <= 1'b1;
			convData <= levels[ch * 10 +: 10];
		end
	end
endmodule

// ==== adcpf_ctrl_tb.sv ====
// Self-checking bench for the converter sequencer.
// Assumes the SAR model and the checker beside it.
`timescale 1ns/100ps
module adcpf_ctrl_tb;
	import adcpf_pkg::*;
	logic		sys_clk = 1'b0;
	logic		rst = 1'b1;
	logic		cyc = 1'b0;
	logic		we = 1'b0;
	logic [7:0]	adr = 8'h00;
	logic [31:0]	wdat = 32'h0000_0000;
	logic [31:0]	rdat, rq;
	logic [2:0]	chan;
	logic [9:0]	data;
	logic		ack, start, done, irq;
	logic [79:0]	levels = 80'h0;
	int		failures = 0;
	int		samples_checked = 0;
	int		cycles = 0;
	int		starts = 0;
	int		s0 = 0;
	adcpf_ctrl adcpf_ctrl_inst (.sys_clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .convStart(start),
		.analogInputChannel(chan), .convDone(done), .convData(data), .conversionEndIrq(irq));
	adcpf_sar_model adcpf_sar_model_inst (.sys_clk, .convStart(start), .analogInputChannel(chan),
		.convDone(done), .convData(data), .levels);
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		starts <= starts + int'(start === 1'b1);
		if (cycles == 6000)
		begin
			failures++;
			complete_run();
		end
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Request held until ack is sampled, then one idle cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
			@(posedge sys_clk);
		while (ack !== 1'b1);
		rq = rdat;
		cyc <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		ck(rq, exp);
	endtask
	task automatic arm(input logic [31:0] cmp, input logic [31:0] sel, input logic [31:0] mode);
		bus(1'b1, ADCPF_OFF_IRQST, 32'h0000_0001);
		bus(1'b1, ADCPF_OFF_THR, 32'h0000_0080);
		bus(1'b1, ADCPF_OFF_CMPM, cmp);
		bus(1'b1, ADCPF_OFF_CHSEL, sel);
		bus(1'b1, ADCPF_OFF_IRQMSK, 32'h0000_0001);
		s0 = starts;
		bus(1'b1, ADCPF_OFF_MODE, mode);
	endtask
	// Threshold equal to channel 0 high part: boundary of the test
	task automatic t_scan_ge;
		levels = {40'h0, 10'h0F3, 10'h2AA, 10'h155, 10'h200};
		arm(32'h0000_0001, 32'h0000_0003, 32'h0000_0007);
		rq = 32'h0000_0001;
		for (int i = 0; i < 40 && rq[0] !== 1'b0; i++)
			bus(1'b0, ADCPF_OFF_MODE, 32'h0000_0000);
		repeat (10) @(posedge sys_clk);
		ck(irq, 1'b1);
		ck(starts - s0, 32'h0000_0004);
		for (int i = 0; i < 4; i++)
			rd(ADCPF_OFF_RES0 + 8'(4 * i), 32'(levels[i * 10 +: 10]));
		rd(ADCPF_OFF_MODE, 32'h0000_0006);
		bus(1'b1, ADCPF_OFF_IRQST, 32'h0000_0001);
		ck(irq, 1'b0);
		$display("one-shot scan over");
	endtask
	// Channel 1 would match; only channel 0 may gate
	task automatic t_scan_miss;
		levels = {60'h0, 10'h000, 10'h200};
		arm(32'h0000_0003, 32'h0000_0001, 32'h0000_0003);
		repeat (60) @(posedge sys_clk);
		ck(irq, 1'b0);
		ck(starts - s0 > 4, 1'b1);
		rd(ADCPF_OFF_RES0, 32'h0000_0200);
		bus(1'b1, ADCPF_OFF_MODE, 32'h0000_0000);
		$display("scan compare miss over");
	endtask
	// Condition 1 with high part just under threshold
	task automatic t_one_sel;
		levels = {50'h0, 10'h1FC, 20'h0};
		arm(32'h0000_0003, 32'h0000_0002, 32'h0000_0005);
		rq = 32'h0000_0001;
		for (int i = 0; i < 20 && rq[0] !== 1'b0; i++)
			bus(1'b0, ADCPF_OFF_MODE, 32'h0000_0000);
		repeat (10) @(posedge sys_clk);
		ck(irq, 1'b1);
		ck(starts - s0, 32'h0000_0001);
		rd(ADCPF_OFF_RES0 + 8'h08, 32'h0000_01FC);
		rd(ADCPF_OFF_MODE, 32'h0000_0004);
		bus(1'b1, ADCPF_OFF_IRQST, 32'h0000_0001);
		$display("one-shot select over");
	endtask
	task automatic t_cont_sel;
		levels = {20'h0, 10'h123, 50'h0};
		arm(32'h0000_0000, 32'h0000_0005, 32'h0000_0001);
		rd(ADCPF_OFF_MODE, 32'h0000_0009);
		repeat (40) @(posedge sys_clk);
		ck(starts - s0 > 3, 1'b1);
		ck(irq, 1'b1);
		rd(ADCPF_OFF_RES0 + 8'h14, 32'h0000_0123);
		bus(1'b1, ADCPF_OFF_IRQMSK, 32'h0000_0000);
		ck(irq, 1'b0);
		bus(1'b1, ADCPF_OFF_MODE, 32'h0000_0000);
		s0 = starts;
		repeat (30) @(posedge sys_clk);
		ck(starts - s0, 32'h0000_0000);
		rd(8'hFC, 32'h0000_0000);
		$display("continuous select over");
	endtask
	initial
	begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		t_scan_ge();
		t_scan_miss();
		t_one_sel();
		t_cont_sel();
		complete_run();
	end
endmodule
bind adcpf_ctrl adcpf_ctrl_chk adcpf_ctrl_chk_inst (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .convStart,
	.analogInputChannel, .convDone, .conversionEndIrq);
